// ===== core/dcmt_map.svh
`ifndef DCMT_MAP_SVH
`define DCMT_MAP_SVH

// bus word addresses of the registers
`define DCMT_IDX_START      32'hFFFF83D0
`define DCMT_IDX_CSR0       32'hFFFF83D2
`define DCMT_IDX_CNT0       32'hFFFF83D4
`define DCMT_IDX_COR0       32'hFFFF83D6
`define DCMT_IDX_CSR1       32'hFFFF83D8
`define DCMT_IDX_CNT1       32'hFFFF83DA
`define DCMT_IDX_COR1       32'hFFFF83DC
`define DCMT_IDX_IRQ_STAT   32'hFFFF83E0
`define DCMT_IDX_IRQ_MASK   32'hFFFF83E2

// select vector positions
`define DCMT_SEL_START      0
`define DCMT_SEL_CH_BASE    1
`define DCMT_SEL_CH_STRIDE  3
`define DCMT_SEL_CSR        0
`define DCMT_SEL_CNT        1
`define DCMT_SEL_COR        2
`define DCMT_SEL_CSR0       (`DCMT_SEL_CH_BASE + `DCMT_SEL_CSR)
`define DCMT_SEL_CNT0       (`DCMT_SEL_CH_BASE + `DCMT_SEL_CNT)
`define DCMT_SEL_COR0       (`DCMT_SEL_CH_BASE + `DCMT_SEL_COR)
`define DCMT_SEL_CSR1       (`DCMT_SEL_CH_BASE + `DCMT_SEL_CH_STRIDE + `DCMT_SEL_CSR)
`define DCMT_SEL_CNT1       (`DCMT_SEL_CH_BASE + `DCMT_SEL_CH_STRIDE + `DCMT_SEL_CNT)
`define DCMT_SEL_COR1       (`DCMT_SEL_CH_BASE + `DCMT_SEL_CH_STRIDE + `DCMT_SEL_COR)
`define DCMT_SEL_IRQ_STAT   7
`define DCMT_SEL_IRQ_MASK   8
`define DCMT_SEL_W          9

// control/status field positions
`define DCMT_FLAG_BIT       7
`define DCMT_IE_BIT         6
`define DCMT_CKS_HI         1
`define DCMT_CKS_LO         0

// reset values
`define DCMT_CNT_RST        16'h0000
`define DCMT_COR_RST        16'hFFFF
`define DCMT_ZERO16         16'h0000

// prescaler taps: log2 of divide ratios 8, 32, 128, 512
`define DCMT_DIV_W          9
`define DCMT_TAP0_LOG2      3
`define DCMT_TAP1_LOG2      5
`define DCMT_TAP2_LOG2      7
`define DCMT_TAP3_LOG2      9
`define DCMT_NUM_TAPS       4

`endif

// ===== core/dcmt_pkg.sv
package dcmt_pkg;

  typedef logic [15:0] dcmt_word_t;

  typedef enum logic [1:0] {
    DCMT_BUS_IDLE = 2'h1,
    DCMT_BUS_ACK  = 2'h2
  } dcmt_bus_e;

endpackage

// ===== core/dcmt_prescaler.sv
`timescale 1ns/10ps
`include "dcmt_map.svh"

module dcmt_prescaler (
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic                        standby,
  output logic      [`DCMT_NUM_TAPS-1:0]   tap_tick
);

  logic [`DCMT_DIV_W-1:0]    div_reg;
  logic [`DCMT_NUM_TAPS-1:0] tap_tick_reg;

  function automatic int dcmt_tap_log2(input int idx);
    case (idx)
      0:       dcmt_tap_log2 = `DCMT_TAP0_LOG2;
      1:       dcmt_tap_log2 = `DCMT_TAP1_LOG2;
      2:       dcmt_tap_log2 = `DCMT_TAP2_LOG2;
      default: dcmt_tap_log2 = `DCMT_TAP3_LOG2;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (srst || standby) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + `DCMT_DIV_W'(1);
    end
  end

  genvar i;
  generate
    for (i = 0; i < `DCMT_NUM_TAPS; i++) begin : g_tap
      localparam logic [`DCMT_DIV_W-1:0] TAP_MASK =
        `DCMT_DIV_W'((1 << dcmt_tap_log2(i)) - 1);
      // one-cycle count enable, so the whole timer stays in clk_sys
      always_ff @(posedge clk_sys) begin
        if (srst || standby) begin
          tap_tick_reg[i] <= 1'b0;
        end else begin
          tap_tick_reg[i] <= ((div_reg & TAP_MASK) == TAP_MASK); // [R16]
        end
      end
    end
  endgenerate

  assign tap_tick = tap_tick_reg;

  a_tap0_period: // [R16]
    assert property (@(posedge clk_sys) disable iff (srst || standby)
      tap_tick_reg[0] |=> !tap_tick_reg[0] [*7] ##1 tap_tick_reg[0])
    else $error("divide-by-8 tick not periodic");

endmodule

// ===== core/dcmt_timer.sv
// Operation
// [R1] two independent channels, each with a 16-bit counter and own interrupt request
// [R2] clock select bits 1:0 pick clock divided by 8, 32, 128 or 512
// [R3] start register bit 1 runs channel 1, bit 0 runs channel 0
// [R4] reserved bits of start and control registers read as zero
// [R5] running counter increments once per selected prescaled tick
// [R6] on counter equal to constant, clear counter and set match flag
// [R7] match flag cleared only by writing 0 after reading 1; writing 1 ignored
// [R8] interrupt request raised while match flag and enable bit are both set
// [R9] counter is fully readable and writable by software
// [R10] constant register sets the match value and so the period
// [R11] reset and standby zero start, control and counter registers
// [R12] reset and standby set constant registers to all ones
// [R13] after a match clear the counter keeps counting from zero
// [R14] match fires on the next tick after equality is reached
// [R15] clear beats counter write; counter write beats increment
// [R16] prescaler gives one-cycle enables so everything runs on clk_sys
`timescale 1ns/10ps
`include "dcmt_map.svh"

module dcmt_timer (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        standby,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  match_irq,
  output logic             irq
);

  localparam int NUM_CH = 2;

  dcmt_pkg::dcmt_bus_e                bus_state_reg;
  dcmt_pkg::dcmt_bus_e                bus_state_next;
  logic [`DCMT_SEL_W-1:0]             sel;
  logic                               bus_req;
  logic                               wr_fire;
  logic                               rd_fire;
  logic [31:0]                        readdata_reg;
  dcmt_pkg::dcmt_word_t               read_mux;
  logic [`DCMT_NUM_TAPS-1:0]          tap_tick;
  logic                               init;

  logic [NUM_CH-1:0]                  run_reg;
  logic [NUM_CH-1:0][15:0]            cnt_reg;
  logic [NUM_CH-1:0][15:0]            cor_reg;
  logic [NUM_CH-1:0]                  flag_reg;
  logic [NUM_CH-1:0]                  armed_reg;
  logic [NUM_CH-1:0]                  ie_reg;
  logic [NUM_CH-1:0][1:0]             cks_reg;
  logic [NUM_CH-1:0]                  irq_stat_reg;
  logic [NUM_CH-1:0]                  irq_mask_reg;
  logic [NUM_CH-1:0]                  tick;
  logic [NUM_CH-1:0]                  match;
  logic [NUM_CH-1:0]                  wr_csr;
  logic [NUM_CH-1:0]                  wr_cnt;
  logic [NUM_CH-1:0]                  wr_cor;
  logic [NUM_CH-1:0]                  rd_csr;

  // one-hot register select; shared by the read mux and the write strobes
  function automatic logic [`DCMT_SEL_W-1:0] dcmt_decode(input logic [31:0] addr);
    dcmt_decode = '0;
    case (addr)
      `DCMT_IDX_START:    dcmt_decode[`DCMT_SEL_START] = 1'b1;
      `DCMT_IDX_CSR0:     dcmt_decode[`DCMT_SEL_CSR0] = 1'b1;
      `DCMT_IDX_CNT0:     dcmt_decode[`DCMT_SEL_CNT0] = 1'b1;
      `DCMT_IDX_COR0:     dcmt_decode[`DCMT_SEL_COR0] = 1'b1;
      `DCMT_IDX_CSR1:     dcmt_decode[`DCMT_SEL_CSR1] = 1'b1;
      `DCMT_IDX_CNT1:     dcmt_decode[`DCMT_SEL_CNT1] = 1'b1;
      `DCMT_IDX_COR1:     dcmt_decode[`DCMT_SEL_COR1] = 1'b1;
      `DCMT_IDX_IRQ_STAT: dcmt_decode[`DCMT_SEL_IRQ_STAT] = 1'b1;
      `DCMT_IDX_IRQ_MASK: dcmt_decode[`DCMT_SEL_IRQ_MASK] = 1'b1;
      default:            dcmt_decode = '0;
    endcase
  endfunction

  // byte lanes 0 and 1 carry the 16-bit registers; lanes 2 and 3 are ignored
  function automatic dcmt_pkg::dcmt_word_t dcmt_merge(input dcmt_pkg::dcmt_word_t old,
                                                      input logic [31:0] wd,
                                                      input logic [3:0]  be);
    dcmt_merge = old;
    if (be[0]) begin
      dcmt_merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      dcmt_merge[15:8] = wd[15:8];
    end
  endfunction

  assign init    = srst || standby;
  assign sel     = dcmt_decode(avs_address);
  assign bus_req = avs_read || avs_write;
  assign wr_fire = avs_write && (bus_state_reg == dcmt_pkg::DCMT_BUS_ACK);
  assign rd_fire = avs_read && (bus_state_reg == dcmt_pkg::DCMT_BUS_ACK);

  // every access takes exactly one wait cycle; readdata is registered meanwhile
  assign avs_waitrequest = bus_req && (bus_state_reg != dcmt_pkg::DCMT_BUS_ACK);
  assign avs_readdata    = readdata_reg;

  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      dcmt_pkg::DCMT_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_next = dcmt_pkg::DCMT_BUS_ACK;
        end
      end
      dcmt_pkg::DCMT_BUS_ACK: begin
        bus_state_next = dcmt_pkg::DCMT_BUS_IDLE;
      end
      default: begin
        bus_state_next = dcmt_pkg::DCMT_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_state_reg <= dcmt_pkg::DCMT_BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  always_comb begin
    read_mux = `DCMT_ZERO16;
    if (sel[`DCMT_SEL_START]) begin
      read_mux[NUM_CH-1:0] = run_reg; // [R4]
    end
    if (sel[`DCMT_SEL_IRQ_STAT]) begin
      read_mux[NUM_CH-1:0] = irq_stat_reg;
    end
    if (sel[`DCMT_SEL_IRQ_MASK]) begin
      read_mux[NUM_CH-1:0] = irq_mask_reg;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (sel[`DCMT_SEL_CH_BASE + `DCMT_SEL_CH_STRIDE * c + `DCMT_SEL_CSR]) begin
        // bits 15:8 and 5:2 stay zero
        read_mux[`DCMT_FLAG_BIT] = flag_reg[c]; // [R4]
        read_mux[`DCMT_IE_BIT]   = ie_reg[c];
        read_mux[`DCMT_CKS_HI:`DCMT_CKS_LO] = cks_reg[c];
      end
      if (sel[`DCMT_SEL_CH_BASE + `DCMT_SEL_CH_STRIDE * c + `DCMT_SEL_CNT]) begin
        read_mux = cnt_reg[c]; // [R9]
      end
      if (sel[`DCMT_SEL_CH_BASE + `DCMT_SEL_CH_STRIDE * c + `DCMT_SEL_COR]) begin
        read_mux = cor_reg[c]; // [R10]
      end
    end
  end

  // unmapped reads return zero, unmapped writes are dropped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      readdata_reg <= 32'h00000000;
    end else if (avs_read && (bus_state_reg == dcmt_pkg::DCMT_BUS_IDLE)) begin
      readdata_reg <= {`DCMT_ZERO16, read_mux};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      run_reg <= '0; // [R11]
    end else if (wr_fire && sel[`DCMT_SEL_START] && avs_byteenable[0]) begin
      run_reg <= avs_writedata[NUM_CH-1:0]; // [R3]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (init) begin
      irq_mask_reg <= '0;
    end else if (wr_fire && sel[`DCMT_SEL_IRQ_MASK] && avs_byteenable[0]) begin
      irq_mask_reg <= avs_writedata[NUM_CH-1:0];
    end
  end

  dcmt_prescaler u_prescaler (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .standby  (standby),
    .tap_tick (tap_tick)
  );

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam int SB = `DCMT_SEL_CH_BASE + `DCMT_SEL_CH_STRIDE * ch;

      assign wr_csr[ch] = wr_fire && sel[SB + `DCMT_SEL_CSR];
      assign wr_cnt[ch] = wr_fire && sel[SB + `DCMT_SEL_CNT];
      assign wr_cor[ch] = wr_fire && sel[SB + `DCMT_SEL_COR];
      assign rd_csr[ch] = rd_fire && sel[SB + `DCMT_SEL_CSR];

      assign tick[ch]  = run_reg[ch] && tap_tick[cks_reg[ch]]; // [R2] [R5]
      // equality alone does nothing: the match waits for the next tick
      assign match[ch] = tick[ch] && (cnt_reg[ch] == cor_reg[ch]); // [R14] [R10]

      always_ff @(posedge clk_sys) begin
        if (init) begin
          cnt_reg[ch] <= `DCMT_CNT_RST; // [R11]
        end else if (match[ch]) begin
          cnt_reg[ch] <= `DCMT_CNT_RST; // [R6] [R13] [R15]
        end else if (wr_cnt[ch]) begin
          cnt_reg[ch] <= dcmt_merge(cnt_reg[ch], avs_writedata, avs_byteenable); // [R9] [R15]
        end else if (tick[ch]) begin
          cnt_reg[ch] <= cnt_reg[ch] + 16'h0001; // [R5]
        end
      end

      always_ff @(posedge clk_sys) begin
        if (init) begin
          cor_reg[ch] <= `DCMT_COR_RST; // [R12]
        end else if (wr_cor[ch]) begin
          cor_reg[ch] <= dcmt_merge(cor_reg[ch], avs_writedata, avs_byteenable); // [R10]
        end
      end

      always_ff @(posedge clk_sys) begin
        if (init) begin
          ie_reg[ch]  <= 1'b0; // [R11]
          cks_reg[ch] <= 2'h0;
        end else if (wr_csr[ch] && avs_byteenable[0]) begin
          ie_reg[ch]  <= avs_writedata[`DCMT_IE_BIT];
          cks_reg[ch] <= avs_writedata[`DCMT_CKS_HI:`DCMT_CKS_LO]; // [R2]
        end
      end

      // a read that returned the flag as one arms the clear
      always_ff @(posedge clk_sys) begin
        if (init) begin
          armed_reg[ch] <= 1'b0;
        end else if (rd_csr[ch] && readdata_reg[`DCMT_FLAG_BIT]) begin
          armed_reg[ch] <= 1'b1;
        end else if (wr_csr[ch] && avs_byteenable[0] && !avs_writedata[`DCMT_FLAG_BIT]) begin
          armed_reg[ch] <= 1'b0;
        end
      end

      // a match in the cycle of the clearing write keeps the flag set
      always_ff @(posedge clk_sys) begin
        if (init) begin
          flag_reg[ch] <= 1'b0;
        end else if (match[ch]) begin
          flag_reg[ch] <= 1'b1; // [R6]
        end else if (wr_csr[ch] && avs_byteenable[0] && armed_reg[ch]
                     && !avs_writedata[`DCMT_FLAG_BIT]) begin
          flag_reg[ch] <= 1'b0; // [R7]
        end
      end

      always_ff @(posedge clk_sys) begin
        if (init) begin
          irq_stat_reg[ch] <= 1'b0;
        end else if (match[ch]) begin
          irq_stat_reg[ch] <= 1'b1;
        end else if (wr_fire && sel[`DCMT_SEL_IRQ_STAT] && avs_byteenable[0]
                     && avs_writedata[ch]) begin
          irq_stat_reg[ch] <= 1'b0;
        end
      end

      assign match_irq[ch] = flag_reg[ch] && ie_reg[ch]; // [R8] [R1]

      a_match_clears_cnt: // [R6]
        assert property (@(posedge clk_sys) disable iff (init)
          match[ch] |=> (cnt_reg[ch] == `DCMT_CNT_RST) && flag_reg[ch])
        else $error("match did not clear counter and set flag");

      a_count_step: // [R5]
        assert property (@(posedge clk_sys) disable iff (init)
          tick[ch] && !match[ch] && !wr_cnt[ch]
          |=> cnt_reg[ch] == $past(cnt_reg[ch]) + 16'h0001)
        else $error("counter did not step by one on tick");

      a_halt_holds: // [R3]
        assert property (@(posedge clk_sys) disable iff (init)
          !run_reg[ch] && !wr_cnt[ch] |=> $stable(cnt_reg[ch]))
        else $error("halted counter changed");

      a_equal_waits: // [R14]
        assert property (@(posedge clk_sys) disable iff (init)
          (cnt_reg[ch] == cor_reg[ch]) && !tick[ch] && !wr_cnt[ch]
          |=> $stable(cnt_reg[ch]) && !$rose(flag_reg[ch]))
        else $error("counter left match value without a tick");

      a_clear_beats_write: // [R15]
        assert property (@(posedge clk_sys) disable iff (init)
          match[ch] && wr_cnt[ch] |=> cnt_reg[ch] == `DCMT_CNT_RST)
        else $error("counter write beat match clear");

      a_write_beats_inc: // [R15]
        assert property (@(posedge clk_sys) disable iff (init)
          wr_cnt[ch] && tick[ch] && !match[ch] && (avs_byteenable[1:0] == 2'h3)
          |=> cnt_reg[ch] == $past(avs_writedata[15:0]))
        else $error("increment beat counter write");

      a_flag_needs_arm: // [R7]
        assert property (@(posedge clk_sys) disable iff (init)
          flag_reg[ch] && (!armed_reg[ch] || avs_writedata[`DCMT_FLAG_BIT])
          |=> flag_reg[ch])
        else $error("flag cleared without read-then-write-zero");

      a_irq_follows: // [R8]
        assert property (@(posedge clk_sys) disable iff (init)
          match[ch] && ie_reg[ch] && !wr_csr[ch] |=> match_irq[ch])
        else $error("enabled match raised no request");

      a_flag_on_match: // [R14]
        assert property (@(posedge clk_sys) disable iff (init)
          $rose(flag_reg[ch]) |-> $past(match[ch]))
        else $error("flag rose without a match tick");

      // the status copy must see every match, also one that lands on a clear
      a_status_on_match: // [R6]
        assert property (@(posedge clk_sys) disable iff (init)
          match[ch] |=> irq_stat_reg[ch])
        else $error("match did not set status");

      a_init_values: // [R12]
        assert property (@(posedge clk_sys)
          init |=> (cor_reg[ch] == `DCMT_COR_RST) && (cnt_reg[ch] == `DCMT_CNT_RST)
                   && !flag_reg[ch] && !ie_reg[ch])
        else $error("initial register values wrong");
    end
  endgenerate

  assign irq = |(irq_stat_reg & irq_mask_reg);

  a_reserved_zero: // [R4]
    assert property (@(posedge clk_sys) disable iff (init)
      rd_fire && (sel[`DCMT_SEL_START] || sel[`DCMT_SEL_CSR0] || sel[`DCMT_SEL_CSR1])
      |-> (avs_readdata[15:8] == 8'h00) && (avs_readdata[5:2] == 4'h0))
    else $error("reserved bits read nonzero");

  a_one_wait: // bus answers after one wait cycle
    assert property (@(posedge clk_sys) disable iff (srst)
      $rose(bus_req) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

endmodule

// ===== bench/dcmt_timer_test.sv
`timescale 1ns/10ps
`include "dcmt_map.svh"

module dcmt_timer_test;
  logic        clk_sys;
  logic        srst;
  logic        standby;
  logic [31:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  match_irq;
  logic        irq;
  int          err_count;
  int          compares;
  int          seed;
  int          cyc;
  int          t0;
  int          t1;
  logic [31:0] rdat;
  logic [15:0] val;
  logic [31:0] regs [7] = '{`DCMT_IDX_START, `DCMT_IDX_CSR0, `DCMT_IDX_CNT0, `DCMT_IDX_COR0,
                            `DCMT_IDX_CSR1, `DCMT_IDX_CNT1, `DCMT_IDX_COR1};

  dcmt_timer DUT (
    .clk_sys         (clk_sys),
    .srst            (srst),
    .standby         (standby),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .match_irq       (match_irq),
    .irq             (irq)
  );

  always #10 clk_sys = ~clk_sys;

  task automatic complete_run;
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // longest path is the divide-by-512 pass, about 5000 cycles in all
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  // request held until the edge that sees waitrequest low; data taken at that edge
  task automatic bus(input logic wr, input logic [31:0] adr, input logic [15:0] wd,
                     input logic [3:0] be);
    @(posedge clk_sys);
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_address    <= adr;
    avs_writedata  <= {16'h0000, wd};
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] adr, input logic [15:0] wd);
    bus(1'b1, adr, wd, 4'h3);
  endtask

  task automatic chk(input logic [31:0] adr, input logic [15:0] exp, input string msg);
    bus(1'b0, adr, 16'h0000, 4'h0);
    check_reg(rdat, {16'h0000, exp}, msg);
  endtask

  function automatic logic [15:0] csr_exp(input logic [15:0] w, input logic flag);
    return {8'h00, flag, w[6], 4'h0, w[1:0]};
  endfunction

  task automatic check_defaults;
    for (int i = 0; i < 7; i++) begin
      chk(regs[i], (i == 3 || i == 6) ? 16'hFFFF : 16'h0000, "init value");
    end
  endtask

  // polls channel 0 request; both polls land on the same phase so differences are exact
  task automatic wait_rise(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (match_irq[0] !== 1'b1 && n < 400);
    t = cyc;
    check_pin(match_irq[0], 1'b1, "match request");
  endtask

  initial begin
    clk_sys = 1'b0;
    srst = 1'b1;
    standby = 1'b0;
    avs_address = 32'h00000000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    err_count = 0;
    compares = 0;
    seed = 32'h4a8e;
    cyc = 0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    check_defaults();
    wr(32'hFFFF83E4, 16'hFFFF);
    chk(32'hFFFF83E4, 16'h0000, "unmapped read");
    wr(`DCMT_IDX_START, 16'h0000);
    chk(`DCMT_IDX_START, 16'h0000, "start reserved");
    wr(`DCMT_IDX_CSR0, 16'h0082);
    chk(`DCMT_IDX_CSR0, csr_exp(16'h0082, 1'b0), "csr0 reserved");
    wr(`DCMT_IDX_CSR1, 16'h0041);
    chk(`DCMT_IDX_CSR1, csr_exp(16'h0041, 1'b0), "csr1 fields");
    for (int i = 2; i < 7; i++) begin
      if (i != 4) begin
        val = 16'($random(seed));
        wr(regs[i], val);
        chk(regs[i], val, "counter or constant");
      end
    end
    wr(`DCMT_IDX_CNT1, 16'h1234);
    bus(1'b1, `DCMT_IDX_CNT1, 16'hABCD, 4'h2);
    chk(`DCMT_IDX_CNT1, 16'hAB34, "byte write");
    for (int s = 0; s < 4; s++) begin
      wr(`DCMT_IDX_CNT0, 16'h0000);
      wr(`DCMT_IDX_COR0, 16'hFFFF);
      wr(`DCMT_IDX_CSR0, 16'(s));
      wr(`DCMT_IDX_START, 16'h0001);
      repeat (6 * (8 << (2 * s))) @(posedge clk_sys);
      wr(`DCMT_IDX_START, 16'h0000);
      bus(1'b0, `DCMT_IDX_CNT0, 16'h0000, 4'h0);
      check_pin(rdat[15:0] >= 5 && rdat[15:0] <= 7, 1'b1, "tick rate");
    end
    val = 16'h0003 + 16'($random(seed) & 7);
    wr(`DCMT_IDX_COR0, val);
    wr(`DCMT_IDX_CNT0, 16'h0000);
    wr(`DCMT_IDX_CSR0, 16'h0040);
    wr(`DCMT_IDX_START, 16'h0001);
    wait_rise(t0);
    chk(`DCMT_IDX_CSR0, 16'h00C0, "flag set");
    bus(1'b0, `DCMT_IDX_CNT0, 16'h0000, 4'h0);
    check_pin(rdat[15:0] <= 1, 1'b1, "restart from zero");
    wr(`DCMT_IDX_CSR0, 16'h0040);
    chk(`DCMT_IDX_CSR0, 16'h0040, "flag cleared");
    check_pin(match_irq[0], 1'b0, "request dropped");
    wait_rise(t1);
    check_reg(32'(t1 - t0), 32'(8 * (val + 1)), "match period");
    wr(`DCMT_IDX_START, 16'h0000);
    chk(`DCMT_IDX_IRQ_STAT, 16'h0001, "status sticky");
    wr(`DCMT_IDX_IRQ_MASK, 16'h0001);
    @(posedge clk_sys);
    check_pin(irq, 1'b1, "irq unmasked");
    wr(`DCMT_IDX_IRQ_MASK, 16'h0000);
    @(posedge clk_sys);
    check_pin(irq, 1'b0, "irq masked");
    wr(`DCMT_IDX_IRQ_STAT, 16'h0003);
    chk(`DCMT_IDX_IRQ_STAT, 16'h0000, "status cleared");
    // flag set again without a read since, so this write must not clear it
    wr(`DCMT_IDX_CSR0, 16'h0040);
    chk(`DCMT_IDX_CSR0, 16'h00C0, "clear without read");
    wr(`DCMT_IDX_CSR0, 16'h0000);
    chk(`DCMT_IDX_CSR0, 16'h0000, "clear after read");
    wr(`DCMT_IDX_COR1, 16'h0004);
    wr(`DCMT_IDX_CNT1, 16'h0000);
    wr(`DCMT_IDX_CSR1, 16'h0000);
    wr(`DCMT_IDX_START, 16'h0002);
    repeat (80) @(posedge clk_sys);
    check_pin(match_irq[1], 1'b0, "request gated");
    chk(`DCMT_IDX_CSR1, 16'h0080, "channel 1 flag");
    chk(`DCMT_IDX_CSR0, 16'h0000, "channel 0 untouched");
    wr(`DCMT_IDX_CSR0, 16'h0000);
    wr(`DCMT_IDX_START, 16'h0001);
    // writes 7 cycles apart walk every phase of the divide-by-8 tick
    for (int k = 0; k < 18; k++) begin
      if (k % 9 == 0) begin
        wr(`DCMT_IDX_COR0, (k == 0) ? 16'hFFFF : 16'h0002);
      end
      val = (k < 9) ? 16'($random(seed)) : 16'h0002;
      wr(`DCMT_IDX_CNT0, val);
      bus(1'b0, `DCMT_IDX_CNT0, 16'h0000, 4'h0);
      val = rdat[15:0] - val;
      check_pin(val <= 16'h0001 || (k > 8 && rdat[15:0] == 16'h0000), 1'b1, "contention");
      @(posedge clk_sys);
    end
    wr(`DCMT_IDX_START, 16'h0003);
    wr(`DCMT_IDX_COR0, 16'($random(seed)));
    wr(`DCMT_IDX_CSR0, 16'h0042);
    @(posedge clk_sys);
    standby <= 1'b1;
    @(posedge clk_sys);
    standby <= 1'b0;
    check_defaults();
    complete_run();
  end
endmodule
